// ==== logic/adac_top.sv ====
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Antenna driver automatic control
// Contract
// [RULE1] Auto-off bit drops drivers after last bit
// [RULE2] Full-depth bit forces 100 percent keying
// [RULE3] Wake bit lets field restart power-down
// [RULE4] Bit 4 reserved, reads zero
// [RULE5] Avoidance bit enables it, picks slot n
// [RULE6] Initial avoidance bit clears when field on
// [RULE7] Software also enables a driver auto-on bit
// [RULE8] Driver 2 on after field gone, delay
// [RULE9] Initial mode: driver 2 needs field-free delay
// [RULE10] Driver 1 on after field gone, delay
// [RULE11] Initial mode: driver 1 needs field-free delay
// [RULE12] Source field picks tristate, coder, pin, high
// [RULE13] Power-down tristates only with tristate code
// [RULE14] High level follows inversion bits
// [RULE15] Auto control at 15h, resets 00h
// [RULE16] Source select at 16h, resets 10h
// [RULE17] Inversion bits per driver on and off
// [RULE18] Aux field drives aux output pin
// [RULE19] Delays are cycle parameters
module adac_top
   import adac_pkg::*;
#(
   parameter int unsigned ACT_DELAY_CYC  = ACTIVE_DELAY_CYC,
   parameter int unsigned INIT_DELAY_CYC = INITIAL_DELAY_CYC
) (
   input  wire logic          clk_sys,
   input  wire logic          reset_n,
   input  wire adac_avs_req_t avs_req,
   output adac_avs_rsp_t      avs_rsp,
   input  wire logic          tx_last_bit_done,
   input  wire logic          coder_envelope,
   input  wire logic          serial_tx_stream,
   input  wire logic          rx_monitor,
   input  wire logic          soft_power_down,
   input  wire logic          field_detect_pin,
   input  wire logic          envelope_input_pin,
   output logic               antenna_driver_1,
   output logic               antenna_driver_1_oe_n,
   output logic               antenna_driver_2,
   output logic               antenna_driver_2_oe_n,
   output logic               aux_output_pin,
   output logic               aux_output_oe_n,
   output logic               full_depth_keying,
   output logic               collision_avoid_active,
   output logic [1:0]         ca_slot_n,
   output logic               wake_request
);
   // ==========================================
   // State
   typedef struct packed {
      logic       ack;        // Bus answer cycle
      logic [7:0] rdata;      // Read data
      logic [7:0] auto_ctrl;  // Automatic control register
      logic [7:0] src_sel;    // Source select register
      logic [7:0] drv_ctrl;   // Inversion and driver on bits
      adac_fsm_t  fsm;        // Switch-on sequencer
      logic       use_init;   // Initial delay in use
      logic [1:0] slot;       // Random slot n
      logic [7:0] lfsr;       // Random source
      logic       field_prev; // Field level last cycle
      logic [1:0] drv_out;    // Driver pin levels
      logic [1:0] drv_oe_n;   // Driver enables, low drives
      logic       aux_out;    // Aux pin level
      logic       aux_oe_n;   // Aux enable, low drives
      logic       wake;       // Wake pulse
   } adac_state_t;

   localparam adac_state_t S_RST = '{
      ack:        1'b0,
      rdata:      8'h00,
      auto_ctrl:  AUTO_RST,
      src_sel:    SRC_RST,
      drv_ctrl:   DRV_CTRL_RST,
      fsm:        FSM_IDLE,
      use_init:   1'b0,
      slot:       2'h0,
      lfsr:       8'h01,
      field_prev: 1'b0,
      drv_out:    2'h0,
      drv_oe_n:   2'h0,
      aux_out:    1'b0,
      aux_oe_n:   1'b1,
      wake:       1'b0
   };

   adac_state_t   s_q;          // Registered state
   adac_state_t   s_d;          // Next state
   logic          rst_n_s;      // Released reset
   logic [1:0]    pins_s;       // Synced field and envelope
   logic          field_s;      // Synced field detect
   logic          env_s;        // Synced envelope input
   logic          bus_req;      // Read or write pending
   logic          bus_wr_take;  // Write completes this edge
   logic [7:0]    idx;          // Register index
   logic [7:0]    rd_val;       // Read mux
   logic [7:0]    wd;           // Write byte
   logic [1:0]    auto_en;      // Driver auto-on bits
   logic          tmr_restart;  // Start a delay
   logic          tmr_done;     // Delay elapsed
   logic [TMR_W-1:0] tmr_target; // Delay length
   logic [1:0]    slot_new;     // Slot for next delay
   adac_drv_src_t drv_src;      // Driver source code
   logic [3:0]    aux_sel;      // Aux source code
   logic [1:0]    drv_out_d;    // Next driver levels
   logic [1:0]    drv_oe_n_d;   // Next driver enables

   // ==========================================
   // Reset release and pin synchronisers
   adac_sync #(
      .W (1)
   ) u_rst_sync (
      .clk   (clk_sys),
      .rst_n (reset_n),
      .d     (1'b1),
      .q     (rst_n_s)
   );

   adac_sync #(
      .W (2)
   ) u_pin_sync (
      .clk   (clk_sys),
      .rst_n (rst_n_s),
      .d     ({envelope_input_pin, field_detect_pin}),
      .q     (pins_s)
   );

   assign field_s = pins_s[0];
   assign env_s   = pins_s[1];

   // ==========================================
   // Decode
   assign bus_req     = avs_req.read | avs_req.write;
   assign bus_wr_take = s_q.ack & avs_req.write & avs_req.byteenable[0];
   assign idx         = avs_req.address[9:2];
   assign wd          = avs_req.writedata[7:0];
   assign auto_en     = s_q.auto_ctrl[1:0];
   assign drv_src     = adac_drv_src_t'(s_q.src_sel[DRV_SEL_LSB +: 2]);
   assign aux_sel     = s_q.src_sel[AUX_SEL_LSB +: 4];
   // Slot n only when avoidance is active
   assign slot_new    = s_q.auto_ctrl[BIT_CA] ? s_q.lfsr[1:0] : 2'h0; // [RULE5]

   // Delay length: initial, or active plus slot wait
   assign tmr_target = s_q.use_init ? TMR_W'(INIT_DELAY_CYC) // [RULE19]
                     : TMR_W'(ACT_DELAY_CYC + s_q.slot * SLOT_CYC);

   // ==========================================
   // Delay timer
   adac_delay_timer u_timer (
      .clk     (clk_sys),
      .rst_n   (rst_n_s),
      .restart (tmr_restart),
      .run     (s_q.fsm == FSM_COUNT),
      .target  (tmr_target),
      .done    (tmr_done)
   );

   // ==========================================
   // Read mux, unmapped reads zero
   always_comb begin
      case (idx)
         IDX_AUTO: begin
            rd_val = s_q.auto_ctrl & AUTO_WMASK; // [RULE4]
         end
         IDX_SRC: begin
            rd_val = s_q.src_sel;
         end
         IDX_DRV_CTRL: begin
            rd_val = s_q.drv_ctrl;
         end
         IDX_STATUS: begin
            rd_val = {2'h0, s_q.slot, s_q.fsm != FSM_IDLE, field_s, s_q.drv_ctrl[1:0]};
         end
         default: begin
            rd_val = 8'h00;
         end
      endcase
   end

   // ==========================================
   // Driver source and inversion, per driver
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_drv
         logic on;   // Driver switched on
         logic inv;  // Inversion for current state
         logic base; // Level before inversion
         assign on  = s_q.drv_ctrl[gi];
         assign inv = on ? s_q.drv_ctrl[BIT_INV_ON + gi] // [RULE17]
                         : s_q.drv_ctrl[BIT_INV_OFF + gi];
         // Source pick
         always_comb begin
            case (drv_src)
               SRC_CODER: begin
                  base = on & coder_envelope; // [RULE12]
               end
               SRC_ENV_PIN: begin
                  base = on & env_s; // [RULE12]
               end
               SRC_HIGH: begin
                  base = 1'b1; // [RULE14]
               end
               default: begin
                  base = 1'b0;
               end
            endcase
         end
         assign drv_out_d[gi] = base ^ inv; // [RULE14]
         // Released only by tristate code, power-down or not
         assign drv_oe_n_d[gi] = (drv_src == SRC_TRISTATE); // [RULE13]
      end
   endgenerate

   // ==========================================
   // Next state
   always_comb begin
      s_d             = s_q;
      tmr_restart     = 1'b0;
      s_d.wake        = 1'b0;
      s_d.field_prev  = field_s;
      s_d.lfsr        = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};
      // Bus answer one cycle after the request
      s_d.ack = bus_req & ~s_q.ack;
      if (bus_req & ~s_q.ack) begin
         s_d.rdata = rd_val;
      end
      // Register writes on the completing edge
      if (bus_wr_take) begin
         case (idx)
            IDX_AUTO: begin
               s_d.auto_ctrl = wd & AUTO_WMASK; // [RULE4]
            end
            IDX_SRC: begin
               s_d.src_sel = wd & SRC_WMASK;
            end
            IDX_DRV_CTRL: begin
               s_d.drv_ctrl = wd & DRV_WMASK;
            end
            default: begin
            end
         endcase
      end
      // Drop all drivers after the final bit
      if (s_q.auto_ctrl[BIT_OFF_AFTER] & tx_last_bit_done) begin
         s_d.drv_ctrl[1:0] = 2'h0; // [RULE1]
      end
      // Automatic switch-on sequencer
      case (s_q.fsm)
         FSM_IDLE: begin
            // Initial avoidance waits for a field-free period
            if (s_q.auto_ctrl[BIT_INIT_CA] && s_q.drv_ctrl[1:0] == 2'h0 && !field_s) begin
               s_d.fsm      = FSM_COUNT; // [RULE9] [RULE11]
               s_d.use_init = 1'b1;
               s_d.slot     = 2'h0;
               tmr_restart  = 1'b1;
            end else if (field_s) begin
               s_d.fsm = FSM_FIELD;
            end
         end
         FSM_FIELD: begin
            // Remote field gone, start active delay
            if (!field_s) begin
               s_d.fsm      = FSM_COUNT; // [RULE8] [RULE10]
               s_d.use_init = 1'b0;
               s_d.slot     = slot_new; // [RULE5]
               tmr_restart  = 1'b1;
            end
         end
         FSM_COUNT: begin
            // Any field during the delay aborts it
            if (field_s) begin
               s_d.fsm = FSM_FIELD; // [RULE9] [RULE11]
            end else if (tmr_done) begin
               s_d.fsm = FSM_ON;
            end
         end
         FSM_ON: begin
            // Only drivers with auto-on set are switched
            s_d.drv_ctrl[1:0]           = s_d.drv_ctrl[1:0] | auto_en; // [RULE8] [RULE10] [RULE7]
            s_d.auto_ctrl[BIT_INIT_CA]  = 1'b0; // [RULE6]
            s_d.fsm                     = FSM_IDLE;
         end
         default: begin
            s_d.fsm = FSM_IDLE;
         end
      endcase
      // No driver asks for auto-on: stay idle
      if (auto_en == 2'h0) begin
         s_d.fsm = FSM_IDLE;
      end
      // Field rising edge restarts from soft power-down
      if (s_q.auto_ctrl[BIT_WAKE] & soft_power_down & field_s & ~s_q.field_prev) begin
         s_d.wake = 1'b1; // [RULE3]
      end
      // Pin levels
      s_d.drv_out  = drv_out_d;
      s_d.drv_oe_n = drv_oe_n_d;
      case (aux_sel)
         AUX_LOW: begin
            s_d.aux_out  = 1'b0; // [RULE18]
            s_d.aux_oe_n = 1'b0;
         end
         AUX_HIGH: begin
            s_d.aux_out  = 1'b1;
            s_d.aux_oe_n = 1'b0;
         end
         AUX_ENV: begin
            s_d.aux_out  = coder_envelope;
            s_d.aux_oe_n = 1'b0;
         end
         AUX_TXSER: begin
            s_d.aux_out  = serial_tx_stream;
            s_d.aux_oe_n = 1'b0;
         end
         AUX_RXOUT, AUX_RXSER: begin
            s_d.aux_out  = rx_monitor;
            s_d.aux_oe_n = 1'b0;
         end
         AUX_TRI: begin
            s_d.aux_out  = 1'b0;
            s_d.aux_oe_n = 1'b1;
         end
         default: begin
            // Monitor codes without a source here drive low
            s_d.aux_out  = 1'b0;
            s_d.aux_oe_n = 1'b0;
         end
      endcase
   end

   // ==========================================
   // State register
   always_ff @(posedge clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         s_q <= S_RST; // [RULE15] [RULE16]
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // Outputs
   assign avs_rsp.readdata     = {24'h000000, s_q.rdata};
   assign avs_rsp.waitrequest  = bus_req & ~s_q.ack;
   assign antenna_driver_1      = s_q.drv_out[0];
   assign antenna_driver_2      = s_q.drv_out[1];
   assign antenna_driver_1_oe_n = s_q.drv_oe_n[0];
   assign antenna_driver_2_oe_n = s_q.drv_oe_n[1];
   assign aux_output_pin        = s_q.aux_out;
   assign aux_output_oe_n       = s_q.aux_oe_n;
   assign full_depth_keying     = s_q.auto_ctrl[BIT_FULL_ASK]; // [RULE2]
   assign collision_avoid_active = s_q.auto_ctrl[BIT_CA]; // [RULE5]
   assign ca_slot_n             = s_q.slot;
   assign wake_request          = s_q.wake;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n_s);

   a_auto_off_drv: assert property ( // [RULE1]
      (s_q.auto_ctrl[BIT_OFF_AFTER] && tx_last_bit_done && s_q.fsm != FSM_ON && !bus_wr_take)
      |=> s_q.drv_ctrl[1:0] == 2'h0)
      else $error("drivers still on after last bit");
   a_keying_write: assert property ( // [RULE2]
      $rose(full_depth_keying) |-> $past(bus_wr_take) && $past(idx) == IDX_AUTO)
      else $error("full depth keying rose without write");
   a_wake_cause: assert property ( // [RULE3]
      wake_request |-> $past(s_q.auto_ctrl[BIT_WAKE] && soft_power_down && field_s))
      else $error("wake without enabled field detect");
   a_rsvd_zero: assert property ( // [RULE4]
      s_q.auto_ctrl[BIT_RSVD] == 1'b0 && s_q.src_sel[7:6] == 2'h0)
      else $error("reserved bit set");
   a_slot_zero: assert property ( // [RULE5]
      (s_q.fsm == FSM_FIELD && !field_s && !s_q.auto_ctrl[BIT_CA] && auto_en != 2'h0)
      |=> ca_slot_n == 2'h0)
      else $error("slot set without avoidance");
   a_init_clear: assert property ( // [RULE6]
      (s_q.fsm == FSM_ON && !bus_wr_take) |=> !s_q.auto_ctrl[BIT_INIT_CA])
      else $error("initial avoidance bit not cleared");
   a_auto_on: assert property ( // [RULE8] [RULE10]
      (s_q.fsm == FSM_ON && !tx_last_bit_done && !bus_wr_take)
      |=> (s_q.drv_ctrl[1:0] & $past(auto_en)) == $past(auto_en))
      else $error("enabled driver not switched on");
   a_field_abort: assert property ( // [RULE9] [RULE11]
      (s_q.fsm == FSM_COUNT && field_s && auto_en != 2'h0) |=> s_q.fsm == FSM_FIELD)
      else $error("delay not aborted by field");
   a_tristate_oe: assert property ( // [RULE13]
      antenna_driver_1_oe_n == ($past(s_q.src_sel[5:4]) == SRC_TRISTATE))
      else $error("driver enable disagrees with source");
   a_high_level: assert property ( // [RULE14]
      ($past(s_q.src_sel[5:4]) == SRC_HIGH)
      |-> antenna_driver_2 == !($past(s_q.drv_ctrl[1]) ? $past(s_q.drv_ctrl[7]) : $past(s_q.drv_ctrl[5])))
      else $error("high level ignores inversion");
   a_aux_low: assert property ( // [RULE18]
      ($past(aux_sel) == AUX_LOW) |-> !aux_output_pin && !aux_output_oe_n)
      else $error("aux low code not driven low");

   c_auto_on: cover property (s_q.fsm == FSM_ON);
   c_init_on: cover property (s_q.fsm == FSM_ON && s_q.use_init);
   c_wake: cover property (wake_request);
   c_auto_off: cover property (s_q.auto_ctrl[BIT_OFF_AFTER] && tx_last_bit_done && s_q.drv_ctrl[1:0] != 2'h0);
endmodule
`default_nettype wire

// ==== logic/adac_pkg.sv ====
`default_nettype none
// ==========================================
// Shared constants for the antenna driver control
package adac_pkg;
   // Core clock rate
   localparam int unsigned CLK_MHZ = 20;
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_DRV_CTRL = 8'h14;
   localparam logic [7:0] IDX_AUTO     = 8'h15;
   localparam logic [7:0] IDX_SRC      = 8'h16;
   localparam logic [7:0] IDX_STATUS   = 8'h1F;
   // Reset values
   localparam logic [7:0] AUTO_RST     = 8'h00;
   localparam logic [7:0] SRC_RST      = 8'h10;
   localparam logic [7:0] DRV_CTRL_RST = 8'h00;
   // Writable bit masks
   localparam logic [7:0] AUTO_WMASK   = 8'hEF;
   localparam logic [7:0] SRC_WMASK    = 8'h3F;
   localparam logic [7:0] DRV_WMASK    = 8'hF3;
   // Automatic control bit positions
   localparam int unsigned BIT_OFF_AFTER = 7;
   localparam int unsigned BIT_FULL_ASK  = 6;
   localparam int unsigned BIT_WAKE      = 5;
   localparam int unsigned BIT_RSVD      = 4;
   localparam int unsigned BIT_CA        = 3;
   localparam int unsigned BIT_INIT_CA   = 2;
   // Driver control: enable at i, invert-on at 6+i, invert-off at 4+i
   localparam int unsigned BIT_INV_ON    = 6;
   localparam int unsigned BIT_INV_OFF   = 4;
   // Source select field positions
   localparam int unsigned DRV_SEL_LSB   = 4;
   localparam int unsigned AUX_SEL_LSB   = 0;
   // Delay times in ns and derived cycle counts, rounded up
   localparam int unsigned ACTIVE_DELAY_NS  = 100000;
   localparam int unsigned INITIAL_DELAY_NS = 500000;
   localparam int unsigned SLOT_NS          = 25000;
   localparam int unsigned ACTIVE_DELAY_CYC  = (ACTIVE_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned INITIAL_DELAY_CYC = (INITIAL_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SLOT_CYC          = (SLOT_NS * CLK_MHZ + 999) / 1000;
   // Delay counter width
   localparam int unsigned TMR_W = 16;
   // Driver source codes
   typedef enum logic [1:0] {
      SRC_TRISTATE = 2'h0,
      SRC_CODER    = 2'h1,
      SRC_ENV_PIN  = 2'h2,
      SRC_HIGH     = 2'h3
   } adac_drv_src_t;
   // Auxiliary output codes
   localparam logic [3:0] AUX_TRI   = 4'h0;
   localparam logic [3:0] AUX_LOW   = 4'h1;
   localparam logic [3:0] AUX_HIGH  = 4'h2;
   localparam logic [3:0] AUX_ENV   = 4'h4;
   localparam logic [3:0] AUX_TXSER = 4'h5;
   localparam logic [3:0] AUX_RXOUT = 4'h6;
   localparam logic [3:0] AUX_RXSER = 4'h7;
   // Automatic switch-on sequencer, Gray along the path
   typedef enum logic [1:0] {
      FSM_IDLE  = 2'h0,
      FSM_FIELD = 2'h1,
      FSM_COUNT = 2'h3,
      FSM_ON    = 2'h2
   } adac_fsm_t;
   // Avalon-MM request and answer
   typedef struct packed {
      logic [9:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } adac_avs_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } adac_avs_rsp_t;
endpackage
`default_nettype wire

// ==== logic/adac_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Two-flop synchroniser, also used for reset release
module adac_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;  // First stage, read only by second
      logic [W-1:0] sync;  // Safe copy
   } adac_sync_t;
   adac_sync_t s_q;
   adac_sync_t s_d;
   // Next stage values
   always_comb begin
      s_d      = s_q;
      s_d.meta = d;
      s_d.sync = s_q.meta;
   end
   // Stage registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign q = s_q.sync;
endmodule
`default_nettype wire

// ==== logic/adac_delay_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Field-free delay counter for automatic switch-on
module adac_delay_timer
   import adac_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             restart,
   input  wire logic             run,
   input  wire logic [TMR_W-1:0] target,
   output logic                  done
);
   typedef struct packed {
      logic [TMR_W-1:0] cnt;  // Cycles elapsed
   } adac_tmr_t;
   adac_tmr_t s_q;
   adac_tmr_t s_d;
   // Count up to target, restart from zero
   always_comb begin
      s_d = s_q;
      if (restart) begin
         s_d.cnt = '0;
      end else if (run && s_q.cnt != target) begin
         s_d.cnt = TMR_W'(s_q.cnt + 1'b1);
      end
   end
   // Counter register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   // Delay elapsed while running
   assign done = run & ~restart & (s_q.cnt == target);
endmodule
`default_nettype wire

// ==== tb/adac_field_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Remote field and external envelope source
module adac_field_model (
   input  wire logic field_on,
   input  wire logic env_level,
   output wire logic field_detect_pin,
   output wire logic envelope_input_pin
);
   // Pins lag the bench command by a skew unrelated to the core clock
   assign #13 field_detect_pin = field_on;
   // Envelope pin follows its level with its own skew
   assign #17 envelope_input_pin = env_level;
endmodule
`default_nettype wire

// ==== tb/antenna_driver_auto_control_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Self-checking bench for the antenna driver control
module antenna_driver_auto_control_tb;
   import adac_pkg::*;
   logic          clk_sys, reset_n, tx_done, spd, fld, env, fpin, epin, coder;
   logic          d1, d1_oe_n, d2, d2_oe_n, aux, aux_oe_n, fdk, ca, wake;
   adac_avs_req_t req;
   adac_avs_rsp_t rsp;
   logic [7:0]    rd;
   logic [1:0]    slot;
   int            mismatches, n_compared;
   // ==========================================
   // Design and remote field
   adac_top #(.ACT_DELAY_CYC(20), .INIT_DELAY_CYC(40)) i_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .avs_req(req), .avs_rsp(rsp),
      .tx_last_bit_done(tx_done), .coder_envelope(coder), .serial_tx_stream(1'b0),
      .rx_monitor(1'b0), .soft_power_down(spd), .field_detect_pin(fpin),
      .envelope_input_pin(epin), .antenna_driver_1(d1), .antenna_driver_1_oe_n(d1_oe_n),
      .antenna_driver_2(d2), .antenna_driver_2_oe_n(d2_oe_n), .aux_output_pin(aux),
      .aux_output_oe_n(aux_oe_n), .full_depth_keying(fdk), .collision_avoid_active(ca),
      .ca_slot_n(slot), .wake_request(wake));
   adac_field_model i_field (.field_on(fld), .env_level(env), .field_detect_pin(fpin),
      .envelope_input_pin(epin));
   // ==========================================
   // Helpers
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         mismatches++;
      end
   endtask
   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      req <= '{address: {idx, 2'b00}, read: !wr, write: wr, writedata: {24'h0, wd}, byteenable: 4'hF};
      // Request stands until the rising edge that sees waitrequest low
      @(posedge clk_sys);
      while (rsp.waitrequest !== 1'b0 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      if (rsp.waitrequest !== 1'b0) begin
         mismatches++;
         wrap_up();
      end
      // Data taken and request released at that same edge
      rd = rsp.readdata[7:0];
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Driver pins sampled mid-cycle: level, oe_n, level, oe_n
   task automatic pins(input string nm, input logic [3:0] exp);
      @(negedge clk_sys);
      chk(nm, {4'h0, exp}, {4'h0, d1, d1_oe_n, d2, d2_oe_n});
      @(posedge clk_sys);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      bus(0, IDX_AUTO, 8'h00);
      chk("auto reset", AUTO_RST, rd);
      bus(0, IDX_SRC, 8'h00);
      chk("source reset", 8'h10, rd);
      $display("test reset done");
   endtask
   task automatic t_bits();
      bus(1, IDX_AUTO, 8'hF8);
      bus(0, IDX_AUTO, 8'h00);
      chk("reserved bit", 8'hE8, rd);
      @(negedge clk_sys);
      chk("keying", 8'h01, {7'h0, fdk});
      chk("avoidance", 8'h01, {7'h0, ca});
      @(posedge clk_sys);
      $display("test bits done");
   endtask
   task automatic t_off();
      bus(1, IDX_DRV_CTRL, 8'h03);
      tx_done <= 1'b1;
      cyc(1);
      tx_done <= 1'b0;
      cyc(2);
      bus(0, IDX_DRV_CTRL, 8'h00);
      chk("auto off", 8'h00, rd);
      $display("test auto off done");
   endtask
   task automatic t_wake();
      logic seen;
      seen = 1'b0;
      spd <= 1'b1;
      fld <= 1'b1;
      repeat (20) begin
         @(negedge clk_sys);
         if (wake === 1'b1) seen = 1'b1;
      end
      chk("wake", 8'h01, {7'h0, seen});
      @(posedge clk_sys);
      spd <= 1'b0;
      $display("test wake done");
   endtask
   task automatic t_auto_on();
      bus(1, IDX_AUTO, 8'h03);
      fld <= 1'b0;
      cyc(15);
      bus(0, IDX_DRV_CTRL, 8'h00);
      chk("early on", 8'h00, rd);
      cyc(30);
      bus(0, IDX_DRV_CTRL, 8'h00);
      chk("auto on", 8'h03, rd);
      chk("slot", 8'h00, {6'h0, slot});
      bus(1, IDX_AUTO, 8'h00);
      bus(1, IDX_DRV_CTRL, 8'h00);
      bus(1, IDX_AUTO, 8'h07);
      cyc(30);
      bus(0, IDX_DRV_CTRL, 8'h00);
      chk("initial early", 8'h00, rd);
      cyc(40);
      bus(0, IDX_DRV_CTRL, 8'h00);
      chk("initial on", 8'h03, rd);
      bus(0, IDX_AUTO, 8'h00);
      chk("initial clear", 8'h03, rd);
      $display("test auto on done");
   endtask
   task automatic t_src();
      bus(1, IDX_AUTO, 8'h00);
      bus(1, IDX_DRV_CTRL, 8'h41);
      bus(1, IDX_SRC, 8'h32);
      cyc(2);
      pins("high level", 4'b0010);
      chk("aux high", 8'h02, {6'h0, aux, aux_oe_n});
      spd <= 1'b1;
      bus(1, IDX_SRC, 8'h00);
      cyc(2);
      @(negedge clk_sys);
      chk("power down tristate", 8'h03, {6'h0, d1_oe_n, d2_oe_n});
      @(posedge clk_sys);
      bus(1, IDX_SRC, 8'h20);
      cyc(3);
      pins("envelope source", 4'b1000);
      env <= 1'b1;
      cyc(3);
      pins("envelope high", 4'b0000);
      coder <= 1'b1;
      bus(1, IDX_SRC, 8'h14);
      cyc(2);
      pins("coder source", 4'b0000);
      chk("aux envelope", 8'h01, {7'h0, aux});
      spd <= 1'b0;
      $display("test source done");
   endtask
   // ==========================================
   // Verdict and end of run
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Clock at 50 ns period
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Main sequence
   initial begin
      {reset_n, tx_done, spd, fld, env, coder} = '0;
      req = '0;
      mismatches = 0;
      n_compared = 0;
      cyc(8);
      reset_n <= 1'b1;
      cyc(3);
      t_reset();
      t_bits();
      t_off();
      t_wake();
      t_auto_on();
      t_src();
      wrap_up();
   end
endmodule
`default_nettype wire
